// ---- rtl/isf_top.sv ----
// Functional notes
// - Same write during a held transfer issues a repeated start.
// - Writing bus-busy 0 and prohibit 0 during a held transfer issues a stop condition.
// - Prohibit bit always reads 1; writing 1 does nothing.
// - Error-halt flag, bit 7: slave two-wire stop during frame.
// - Normal-halt flag, bit 6: slave two-wire stop detected outside a frame.
// - Error-halt clears by read-1-write-0 or interface irq clear.
// - Normal-halt clears by read-1-write-0 or interface irq clear.
// - Slave mode: continuous irq sets on empty/full rise with address-2 match.
// - Other modes: continuous irq sets on empty/full rise.
// - Continuous irq clears by read-1-write-0 or interface irq clear.
// - Address-2 match, bit 4: set in slave receive when format select 0.
// - Address-2 match clears by read-1-write-0 or start detect.
// - Arbitration-lost, bit 3: set when master loses arbitration.
// - Arbitration-lost clears by read-1-write-0.
// - Arbitration-lost clears on data write (tx) or data read (rx).
// - Interface irq clears only by read-1-write-0, clearing dependents.
// - Slave two-wire: interface irq sets when a stop is detected.
`timescale 1ns/1ps
`default_nettype none
module isf_top #(
  parameter int HOLD_CYC = isf_pkg::COND_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire isf_pkg::isf_mode_s mode,
  input wire isf_pkg::isf_event_s events,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output isf_pkg::isf_flags_s status_flags,
  output logic bus_busy
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write, ctrl_write, status_write;
  logic start_req, stop_req;
  logic [1:0] line_sync;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic start_det, stop_det;
  logic te_d_reg, rf_d_reg, te_rise, rf_rise;
  logic [7:0] armed_reg, status_rd;
  logic [7:0] clr_by_sw;
  logic two_wire_slave, if_irq_set, if_irq_clear;
  logic cg_scl_oe_n, cg_sda_oe_n, cg_active;

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  // Address and data are taken in either order; response follows both
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !do_write;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !do_write;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= isf_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg[7:2] == isf_pkg::ADDR_CTRL[7:2] ||
                      awaddr_reg[7:2] == isf_pkg::ADDR_STATUS[7:2]) ?
                     isf_pkg::RESP_OKAY : isf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits
  assign ctrl_write = do_write && wstrb_reg[0] &&
                      awaddr_reg[7:2] == isf_pkg::ADDR_CTRL[7:2];
  assign status_write = do_write && wstrb_reg[0] &&
                        awaddr_reg[7:2] == isf_pkg::ADDR_STATUS[7:2];

  // ----------------------------------------
  // Start and stop requests
  // ----------------------------------------
  // Prohibit written 1 is dropped, so such a write never moves the bus
  assign start_req = ctrl_write && !wdata_reg[isf_pkg::CTRL_PROHIBIT_BIT] &&
                     wdata_reg[isf_pkg::CTRL_BUSY_BIT];
  assign stop_req = ctrl_write && !wdata_reg[isf_pkg::CTRL_PROHIBIT_BIT] &&
                    !wdata_reg[isf_pkg::CTRL_BUSY_BIT];

  // Mode is the requester's duty; a start outside master transmit is still sent
  isf_cond_gen #(
    .HOLD_CYC(HOLD_CYC)
  ) u_cond_gen (
    .core_clk(core_clk),
    .rst(rst),
    .start_req(start_req),
    .stop_req(stop_req),
    .scl_level(scl_s),
    .scl_oe_n(cg_scl_oe_n),
    .sda_oe_n(cg_sda_oe_n),
    .active(cg_active)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_oe_n <= cg_scl_oe_n;
      sda_oe_n <= cg_sda_oe_n;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bus line sampling and condition detect
  // ----------------------------------------
  isf_sync #(
    .WIDTH(2)
  ) u_line_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      bus_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // Data flag edges
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      te_d_reg <= 1'b0;
      rf_d_reg <= 1'b0;
    end else begin
      te_d_reg <= events.transmit_empty;
      rf_d_reg <= events.receive_full;
    end
  end

  assign te_rise = events.transmit_empty && !te_d_reg;
  assign rf_rise = events.receive_full && !rf_d_reg;
  assign two_wire_slave = mode.slave_mode && mode.two_wire_format;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Software clears a flag only if it saw it as 1 and now writes 0
  assign clr_by_sw = status_write ? (armed_reg & ~wdata_reg[7:0]) : 8'h00;
  // A set that wins over the clear must not wipe the dependent flags either
  assign if_irq_set = (two_wire_slave && stop_det) || events.other_irq_set;
  assign if_irq_clear = clr_by_sw[isf_pkg::ST_IF_IRQ_BIT] && !if_irq_set;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr[7:2] == isf_pkg::ADDR_STATUS[7:2]) begin
      armed_reg <= status_rd;
    end else if (status_write) begin
      armed_reg <= armed_reg & wdata_reg[7:0];
    end
  end

  // In every flag below a set in the same cycle wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.err_halt <= isf_pkg::STATUS_RESET[isf_pkg::ST_ERR_HALT_BIT];
    end else if (two_wire_slave && stop_det && mode.frame_active) begin
      status_flags.err_halt <= 1'b1;
    end else if (clr_by_sw[isf_pkg::ST_ERR_HALT_BIT] || if_irq_clear) begin
      status_flags.err_halt <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.norm_halt <= isf_pkg::STATUS_RESET[isf_pkg::ST_NORM_HALT_BIT];
    end else if (two_wire_slave && stop_det && !mode.frame_active) begin
      status_flags.norm_halt <= 1'b1;
    end else if (clr_by_sw[isf_pkg::ST_NORM_HALT_BIT] || if_irq_clear) begin
      status_flags.norm_halt <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.cont_irq <= isf_pkg::STATUS_RESET[isf_pkg::ST_CONT_IRQ_BIT];
    end else if ((te_rise || rf_rise) && mode.slave_mode && status_flags.addr2_match) begin
      status_flags.cont_irq <= 1'b1;
    end else if ((te_rise || rf_rise) && !mode.slave_mode) begin
      status_flags.cont_irq <= 1'b1;
    end else if (clr_by_sw[isf_pkg::ST_CONT_IRQ_BIT] || if_irq_clear) begin
      status_flags.cont_irq <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.addr2_match <= isf_pkg::STATUS_RESET[isf_pkg::ST_ADDR2_BIT];
    end else if (events.second_address_hit && mode.slave_mode && !mode.transmit_mode &&
                 !mode.second_address_format_select) begin
      status_flags.addr2_match <= 1'b1;
    end else if (clr_by_sw[isf_pkg::ST_ADDR2_BIT] || start_det) begin
      status_flags.addr2_match <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.arb_lost <= isf_pkg::STATUS_RESET[isf_pkg::ST_ARB_LOST_BIT];
    end else if (events.arb_loss && !mode.slave_mode) begin
      status_flags.arb_lost <= 1'b1;
    end else if (clr_by_sw[isf_pkg::ST_ARB_LOST_BIT]) begin
      status_flags.arb_lost <= 1'b0;
    end else if ((events.data_write && mode.transmit_mode) ||
                 (events.data_read && !mode.transmit_mode)) begin
      status_flags.arb_lost <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags.if_irq <= isf_pkg::STATUS_RESET[isf_pkg::ST_IF_IRQ_BIT];
    end else if (if_irq_set) begin
      status_flags.if_irq <= 1'b1;
    end else if (if_irq_clear) begin
      status_flags.if_irq <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_comb begin
    status_rd = 8'h00;
    status_rd[isf_pkg::ST_ERR_HALT_BIT] = status_flags.err_halt;
    status_rd[isf_pkg::ST_NORM_HALT_BIT] = status_flags.norm_halt;
    status_rd[isf_pkg::ST_CONT_IRQ_BIT] = status_flags.cont_irq;
    status_rd[isf_pkg::ST_ADDR2_BIT] = status_flags.addr2_match;
    status_rd[isf_pkg::ST_ARB_LOST_BIT] = status_flags.arb_lost;
    status_rd[isf_pkg::ST_IF_IRQ_BIT] = status_flags.if_irq;
    status_rd = status_rd & isf_pkg::STATUS_IMPL_MASK;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= isf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isf_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == isf_pkg::ADDR_CTRL[7:2]) begin
        s_axi_rdata <= {24'h000000, bus_busy, 6'h00, 1'b1};
      end else if (s_axi_araddr[7:2] == isf_pkg::ADDR_STATUS[7:2]) begin
        s_axi_rdata <= {24'h000000, status_rd};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= isf_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/isf_pkg.sv ----
package isf_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_BUSY_BIT = 7;
  localparam int CTRL_PROHIBIT_BIT = 0;
  localparam int ST_ERR_HALT_BIT = 7;
  localparam int ST_NORM_HALT_BIT = 6;
  localparam int ST_CONT_IRQ_BIT = 5;
  localparam int ST_ADDR2_BIT = 4;
  localparam int ST_ARB_LOST_BIT = 3;
  localparam int ST_IF_IRQ_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'hFA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int COND_HOLD_NS = 4000;
  localparam int COND_HOLD_CYC = (COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic err_halt;
    logic norm_halt;
    logic cont_irq;
    logic addr2_match;
    logic arb_lost;
    logic if_irq;
  } isf_flags_s;
  typedef struct packed {
    logic slave_mode;
    logic two_wire_format;
    logic transmit_mode;
    logic second_address_format_select;
    logic frame_active;
  } isf_mode_s;
  typedef struct packed {
    logic transmit_empty;
    logic receive_full;
    logic second_address_hit;
    logic arb_loss;
    logic data_write;
    logic data_read;
    logic other_irq_set;
  } isf_event_s;
  typedef enum logic [3:0] {
    CG_IDLE = 4'h0,
    CG_START_SDA = 4'h1,
    CG_START_SCL = 4'h3,
    CG_HOLD = 4'h2,
    CG_STOP_PRE = 4'h6,
    CG_STOP_SCL = 4'h7,
    CG_STOP_SDA = 4'h5,
    CG_RS_SDA = 4'hC,
    CG_RS_SCL = 4'hD
  } isf_cond_e;
endpackage

// ---- rtl/isf_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module isf_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // Reset to released-bus level so no false edge follows reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/isf_cond_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module isf_cond_gen #(
  parameter int HOLD_CYC = isf_pkg::COND_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic scl_level,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic active
);
  isf_pkg::isf_cond_e state_reg, state_next;
  logic [15:0] tick_cnt_reg;
  logic tick;

  // ----------------------------------------
  // Hold-time divider
  // ----------------------------------------
  assign tick = (tick_cnt_reg == 16'(HOLD_CYC - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
    end else if (state_reg != state_next || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else if (state_reg != isf_pkg::CG_IDLE && state_reg != isf_pkg::CG_HOLD) begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Condition sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      isf_pkg::CG_IDLE: if (start_req) state_next = isf_pkg::CG_START_SDA;
      isf_pkg::CG_START_SDA: if (tick) state_next = isf_pkg::CG_START_SCL;
      isf_pkg::CG_START_SCL: if (tick) state_next = isf_pkg::CG_HOLD;
      isf_pkg::CG_HOLD: begin
        if (start_req) state_next = isf_pkg::CG_RS_SDA;
        else if (stop_req) state_next = isf_pkg::CG_STOP_PRE;
      end
      isf_pkg::CG_RS_SDA: if (tick) state_next = isf_pkg::CG_RS_SCL;
      // Slaves may stretch the clock, so wait for the line to rise
      isf_pkg::CG_RS_SCL: if (tick && scl_level) state_next = isf_pkg::CG_START_SDA;
      isf_pkg::CG_STOP_PRE: if (tick) state_next = isf_pkg::CG_STOP_SCL;
      isf_pkg::CG_STOP_SCL: if (tick && scl_level) state_next = isf_pkg::CG_STOP_SDA;
      isf_pkg::CG_STOP_SDA: if (tick) state_next = isf_pkg::CG_IDLE;
      default: state_next = isf_pkg::CG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= isf_pkg::CG_IDLE;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      active <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_oe_n <= !(state_next inside {isf_pkg::CG_START_SCL, isf_pkg::CG_HOLD,
                                       isf_pkg::CG_RS_SDA, isf_pkg::CG_STOP_PRE});
      sda_oe_n <= !(state_next inside {isf_pkg::CG_START_SDA, isf_pkg::CG_START_SCL,
                                       isf_pkg::CG_STOP_PRE, isf_pkg::CG_STOP_SCL});
      active <= (state_next != isf_pkg::CG_IDLE);
    end
  end
endmodule
`default_nettype wire

// ---- test/isf_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module isf_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire isf_pkg::isf_mode_s mode,
  input wire isf_pkg::isf_event_s events,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire isf_pkg::isf_flags_s status_flags
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  a_start_order: assert property ($fell(scl_oe_n) |-> $past(!sda_oe_n, 3))
    else $error("clock pulled before data held low");
  a_stop_order: assert property ($rose(sda_oe_n) && scl_oe_n |-> $past(scl_oe_n, 3))
    else $error("data released too soon after clock");
  a_err_cause: assert property ($rose(status_flags.err_halt)
    |-> $past(mode.slave_mode && mode.two_wire_format && mode.frame_active)) else $error("error halt without cause");
  a_norm_cause: assert property ($rose(status_flags.norm_halt)
    |-> $past(mode.slave_mode && mode.two_wire_format && !mode.frame_active)) else $error("normal halt without cause");
  a_halt_irq: assert property ($rose(status_flags.err_halt || status_flags.norm_halt) |-> status_flags.if_irq)
    else $error("halt without interface irq");
  a_dep_clear: assert property ($fell(status_flags.if_irq)
    |-> !(status_flags.err_halt || status_flags.norm_halt || status_flags.cont_irq)) else $error("dependent flag kept");
  a_cont_cause: assert property ($rose(status_flags.cont_irq)
    |-> $past((events.transmit_empty || events.receive_full) && (!mode.slave_mode || status_flags.addr2_match)))
    else $error("continuous irq without cause");
  a_arb_cause: assert property ($rose(status_flags.arb_lost) |-> $past(events.arb_loss && !mode.slave_mode))
    else $error("arbitration lost without cause");
  a_arb_clear: assert property (events.data_write && mode.transmit_mode && !events.arb_loss
    |-> ##[1:2] !status_flags.arb_lost) else $error("arbitration lost kept after data write");
endmodule
bind isf_top isf_checker u_chk (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .mode(mode), .events(events), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
  .status_flags(status_flags));
`default_nettype wire

// ---- test/isf_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module isf_bus_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_line,
  output logic sda_line
);
  logic peer_scl_low;
  logic peer_sda_low;
  int stretch_ns;
  // ----------------------------------------
  // Open-drain lines with pull-ups
  // ----------------------------------------
  assign scl_line = scl_oe_n && !peer_scl_low;
  assign sda_line = sda_oe_n && !peer_sda_low;
  initial begin
    peer_scl_low = 1'b0;
    peer_sda_low = 1'b0;
    stretch_ns = 0;
  end
  // Slow peer holds the clock low after release, so the stop must wait for it
  always @(posedge scl_oe_n) begin
    if (stretch_ns > 0) begin
      peer_scl_low = 1'b1;
      #(stretch_ns) peer_scl_low = 1'b0;
    end
  end
  // Another master: start while clock high, one 160 ns clock period, then stop
  task automatic other_frame();
    #7 peer_sda_low = 1'b1;
    #80 peer_scl_low = 1'b1;
    #80 peer_scl_low = 1'b0;
    #80 peer_sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/isf_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module isf_top_test;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scl_line, sda_line, scl_oe_n, sda_oe_n, bus_busy;
  logic scl_out, sda_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  isf_pkg::isf_mode_s mode;
  isf_pkg::isf_event_s events;
  isf_pkg::isf_flags_s status_flags;
  int num_errors, n_compared, seed;
  logic [33:0] exp_q[$];
  isf_top #(.HOLD_CYC(4)) u_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mode(mode), .events(events), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status_flags(status_flags), .bus_busy(bus_busy));
  isf_bus_model u_bus (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_line(scl_line), .sda_line(sda_line));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Answers are matched in order, so every access must queue its expectation first
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk("write answer", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk("read data", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [33:0] e);
    int k;
    exp_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awprot <= 3'($random(seed));
    s_axi_arprot <= 3'($random(seed));
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (k = 0; k < 200; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    if (k == 200) begin
      num_errors++;
      end_sim();
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rs(input logic [7:0] v);
    xfer(1'b0, isf_pkg::ADDR_STATUS, 8'h00, {isf_pkg::RESP_OKAY, 24'h0, v});
  endtask
  task automatic ws(input logic [7:0] d);
    xfer(1'b1, isf_pkg::ADDR_STATUS, d, {isf_pkg::RESP_OKAY, 32'h0});
  endtask
  task automatic wc(input logic [7:0] d);
    xfer(1'b1, isf_pkg::ADDR_CTRL, d, {isf_pkg::RESP_OKAY, 32'h0});
  endtask
  task automatic pulse(input int b);
    events[b] <= 1'b1;
    repeat (3) @(posedge core_clk);
    events[b] <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 3000 && bus_busy !== v; k++) @(posedge core_clk);
    if (k == 3000) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic peer_frame();
    u_bus.other_frame();
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    int i;
    logic [7:0] a;
    seed = 41;
    num_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready, mode, events} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, isf_pkg::ADDR_CTRL, 8'h00, {isf_pkg::RESP_OKAY, 32'h1});
    rs(8'h00);
    for (i = 0; i < 4; i++) begin
      a = 8'h80 | (8'($random(seed)) & 8'h7C);
      xfer(1'b1, a, 8'($random(seed)), {isf_pkg::RESP_SLVERR, 32'h0});
      xfer(1'b0, a, 8'h00, {isf_pkg::RESP_SLVERR, 32'h0});
    end
    mode <= 5'b00100;
    wc(8'h81);
    repeat (20) @(posedge core_clk);
    chk("lines idle", {30'h0, scl_out, sda_out, scl_oe_n, sda_oe_n}, 34'h3);
    wc(8'h80);
    wait_busy(1'b1);
    chk("bus busy", {33'h0, bus_busy}, 34'h1);
    xfer(1'b0, isf_pkg::ADDR_CTRL, 8'h00, {isf_pkg::RESP_OKAY, 32'h81});
    u_bus.stretch_ns = 400;
    wc(8'h80);
    repeat (12) @(posedge core_clk);
    chk("start clock released", {33'h0, scl_oe_n}, 34'h1);
    repeat (68) @(posedge core_clk);
    chk("repeated start", {32'h0, bus_busy, scl_oe_n}, 34'h2);
    wc(8'h00);
    wait_busy(1'b0);
    chk("lines released", {32'h0, scl_oe_n, sda_oe_n}, 34'h3);
    u_bus.stretch_ns = 0;
    mode <= 5'b11000;
    peer_frame();
    rs(8'h42);
    ws(8'hFF);
    rs(8'h42);
    ws(8'h00);
    rs(8'h00);
    mode.frame_active <= 1'b1;
    peer_frame();
    rs(8'h82);
    ws(8'h7F);
    rs(8'h02);
    ws(8'h00);
    rs(8'h00);
    mode <= 5'b11000;
    pulse(6);
    rs(8'h00);
    pulse(4);
    rs(8'h10);
    pulse(5);
    rs(8'h30);
    ws(8'hDF);
    rs(8'h10);
    peer_frame();
    rs(8'h42);
    ws(8'h00);
    mode <= 5'b00100;
    pulse(6);
    pulse(0);
    rs(8'h22);
    ws(8'h00);
    rs(8'h00);
    pulse(3);
    rs(8'h08);
    pulse(2);
    rs(8'h00);
    mode <= 5'b00000;
    pulse(3);
    pulse(1);
    rs(8'h00);
    pulse(3);
    ws(8'h00);
    rs(8'h08);
    ws(8'h00);
    rs(8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
